/* design/windowed_safety_watchdog.sv */
// windowed safety watchdog with simple and challenge modes, avalon-mm slave
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module windowed_safety_watchdog
  import wd_pkg::*;
#(
  parameter int unsigned WD_MS_CYCLES = MS_CYCLES,
  parameter int unsigned WD_RESET_CYCLES = RESET_PULSE_CYCLES
)
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic fused_mode_select_in,
  input wire logic fused_recovery_enable_in,
  input wire logic mcu_fault_inputs_in,
  output logic reset_output_n_out,
  output logic safe_state_output_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  wd_state_t state_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [3:0] window_period_sel_reg;
  logic [2:0] window_duty_sel_reg;
  logic [3:0] recovery_duration_sel_reg;
  logic [1:0] error_limit_sel_reg;
  logic [1:0] refresh_limit_sel_reg;
  logic [1:0] error_reaction_sel_reg;
  logic [3:0] act_period_reg;
  logic [2:0] act_duty_reg;
  logic [15:0] seed_reg;
  logic [15:0] lfsr_reg;
  logic [3:0] error_count_value_reg;
  logic [2:0] refresh_count_value_reg;
  logic [31:0] cnt_reg;
  logic [31:0] rst_cnt_reg;
  logic comm_err_reg;
  logic safe_reg;

  logic wr_take;
  logic in_init;
  logic disabled;
  logic [3:0] cur_code;
  logic [31:0] win_len;
  logic [31:0] closed_len;
  logic closed_now;
  logic win_end;
  logic ans_wr;
  logic [15:0] expected;
  logic good;
  logic bad;
  logic rec_timeout;
  logic trip_reset;
  logic trip_safe;
  logic enter_recover;
  logic seed_wr;
  logic seed_bad;
  logic [3:0] err_lim;
  logic [2:0] rfr_lim;
  logic [4:0] err_plus;

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle per access, write and read data at the
  // edge where waitrequest is seen low

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
  assign wr_take = avs_write_in & ack_reg;
  assign avs_readdata_out = rdata_reg;

  // ack toggles high for exactly the second cycle of each access
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
  end

  // read data captured in the wait cycle so it stands when waitrequest drops
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_reg <= 32'h0000_0000;
    else if (avs_read_in && !ack_reg)
    begin
      rdata_reg <= 32'h0000_0000;
      if (avs_address_in == OFS_WINDOW)
      begin
        rdata_reg[WIN_PERIOD_LSB +: 4] <= window_period_sel_reg;
        rdata_reg[WIN_DUTY_LSB +: 3] <= window_duty_sel_reg;
        rdata_reg[WIN_RECOV_LSB +: 4] <= recovery_duration_sel_reg;
      end
      else if (avs_address_in == OFS_CONFIG)
      begin
        rdata_reg[CFG_ERRLIM_LSB +: 2] <= error_limit_sel_reg;
        rdata_reg[CFG_RFRLIM_LSB +: 2] <= refresh_limit_sel_reg;
        rdata_reg[CFG_REACT_LSB +: 2] <= error_reaction_sel_reg;
      end
      else if (avs_address_in == OFS_SEED)
        rdata_reg[15:0] <= seed_reg;
      else if (avs_address_in == OFS_ANSWER)
        rdata_reg[15:0] <= lfsr_reg; // current question
      else if (avs_address_in == OFS_STATUS)
      begin
        rdata_reg[ST_ERR_LSB +: 4] <= error_count_value_reg;
        rdata_reg[ST_RFR_LSB +: 3] <= refresh_count_value_reg;
        rdata_reg[ST_INIT_BIT] <= in_init;
        rdata_reg[ST_COMM_BIT] <= comm_err_reg;
        rdata_reg[ST_SAFE_BIT] <= safe_reg;
        rdata_reg[ST_DIS_BIT] <= disabled;
        rdata_reg[ST_RECOV_BIT] <= (state_reg == ST_RECOVER);
        rdata_reg[ST_CLOSED_BIT] <= closed_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // window timing

  assign in_init = (state_reg == ST_INIT);
  // a disabled window only exists once init is closed
  assign disabled = (state_reg == ST_RUN) &&
                    (act_period_reg == CODE_DISABLE);
  assign err_lim = err_max(error_limit_sel_reg);
  assign rfr_lim = rfr_max(refresh_limit_sel_reg);

  // recovery uses the same code table, with no closed part
  always_comb
  begin
    cur_code = act_period_reg;
    if (state_reg == ST_RECOVER)
      cur_code = recovery_duration_sel_reg;
    win_len = 32'(period_ms(cur_code)) * 32'(WD_MS_CYCLES);
    closed_len = (win_len >> 4) * 32'(closed_16ths(act_duty_reg));
    if (state_reg == ST_RECOVER)
      closed_len = 32'h0000_0000;
  end

  assign closed_now = (state_reg == ST_RUN) && !disabled &&
                      (cnt_reg < closed_len);
  assign win_end = (cnt_reg == win_len - 32'h0000_0001);

  ////////////////////////////////////////////////////////////////////////////
  // refresh evaluation

  assign ans_wr = wr_take && (avs_address_in == OFS_ANSWER) &&
                  (state_reg != ST_RESET) && !disabled;

  // challenge answers depend on the question, simple ones on the seed
  assign expected = fused_mode_select_in ? challenge_answer(lfsr_reg)
                                         : seed_reg;

  // init counts as open so the first good answer closes it
  assign good = ans_wr && (avs_writedata_in[15:0] == expected) &&
                !closed_now;
  // wrong answer, correct one too early, or silence through the window
  assign bad = (ans_wr && !good) ||
               ((state_reg == ST_RUN) && !disabled && win_end &&
                !ans_wr);
  assign rec_timeout = (state_reg == ST_RECOVER) && win_end &&
                       !ans_wr;

  assign trip_safe = (error_count_value_reg == err_lim) &&
                     (error_reaction_sel_reg != REACT_RESET);
  assign trip_reset = trip_safe &&
                      (error_reaction_sel_reg != REACT_SAFE);
  assign enter_recover = (state_reg == ST_RUN) && fused_recovery_enable_in &&
                         mcu_fault_inputs_in &&
                         (recovery_duration_sel_reg != CODE_DISABLE);

  assign seed_wr = wr_take && (avs_address_in == OFS_SEED);
  assign seed_bad = (avs_writedata_in[15:0] == SEED_ZERO) ||
                    (!fused_mode_select_in &&
                     (avs_writedata_in[15:0] == SEED_ONES));

  ////////////////////////////////////////////////////////////////////////////
  // fail-safe state machine

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      state_reg <= ST_INIT;
    else
    begin
      case (state_reg)
        ST_INIT:
          if (trip_reset)
            state_reg <= ST_RESET;
          else if (good)
            state_reg <= ST_RUN;
        ST_RUN:
          if (trip_reset)
            state_reg <= ST_RESET;
          else if (enter_recover)
            state_reg <= ST_RECOVER;
        ST_RECOVER:
          if (rec_timeout || trip_reset)
            state_reg <= ST_RESET;
          else if (good && !mcu_fault_inputs_in)
            state_reg <= ST_RUN;
        ST_RESET:
          if (rst_cnt_reg == WD_RESET_CYCLES - 32'h0000_0001)
            state_reg <= ST_INIT;
        default:
          state_reg <= ST_INIT;
      endcase
    end
  end

  // reset pulse length counter
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rst_cnt_reg <= 32'h0000_0000;
    else if (state_reg == ST_RESET)
      rst_cnt_reg <= rst_cnt_reg + 32'h0000_0001;
    else
      rst_cnt_reg <= 32'h0000_0000;
  end

  // window counter restarts on every refresh and on each phase change
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cnt_reg <= 32'h0000_0000;
    else if (good || bad || rec_timeout || enter_recover ||
             state_reg == ST_INIT || state_reg == ST_RESET || disabled)
      cnt_reg <= 32'h0000_0000;
    else
      cnt_reg <= cnt_reg + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // period (except to disable code 0) and duty may change any time, locked fields only during init
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      window_period_sel_reg <= PERIOD_RESET;
      window_duty_sel_reg <= DUTY_RESET;
      recovery_duration_sel_reg <= RECOV_RESET;
    end
    else if (wr_take && avs_address_in == OFS_WINDOW)
    begin
      if (in_init ||
          avs_writedata_in[WIN_PERIOD_LSB +: 4] != CODE_DISABLE)
        window_period_sel_reg <=
          avs_writedata_in[WIN_PERIOD_LSB +: 4];
      window_duty_sel_reg <= avs_writedata_in[WIN_DUTY_LSB +: 3];
      if (in_init)
        recovery_duration_sel_reg <=
          avs_writedata_in[WIN_RECOV_LSB +: 4];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      error_limit_sel_reg <= ERRLIM_RESET;
      refresh_limit_sel_reg <= RFRLIM_RESET;
      error_reaction_sel_reg <= REACT_RESET;
    end
    else if (wr_take && avs_address_in == OFS_CONFIG && in_init)
    begin
      error_limit_sel_reg <= avs_writedata_in[CFG_ERRLIM_LSB +: 2];
      refresh_limit_sel_reg <=
        avs_writedata_in[CFG_RFRLIM_LSB +: 2];
      error_reaction_sel_reg <= avs_writedata_in[CFG_REACT_LSB +: 2];
    end
  end

  // running settings only move at a refresh or a timeout, so a window never changes length
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      act_period_reg <= PERIOD_RESET;
      act_duty_reg <= DUTY_RESET;
    end
    else if (good || bad)
    begin
      act_period_reg <= window_period_sel_reg;
      act_duty_reg <= window_duty_sel_reg;
    end
  end

  // seed accepted during init only; bad values leave seed and question untouched and set the comm error
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      seed_reg <= SEED_RESET;
    else if (seed_wr && !seed_bad && in_init)
      seed_reg <= avs_writedata_in[15:0];
  end

  // question is reloaded by a good seed write in init and steps only on a good challenge answer
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      lfsr_reg <= SEED_RESET;
    else if (seed_wr && !seed_bad && in_init)
      lfsr_reg <= avs_writedata_in[15:0];
    else if (good && fused_mode_select_in)
      lfsr_reg <= lfsr_step(lfsr_reg);
  end

  // sticky communication error, write one to clear; a new event wins
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      comm_err_reg <= 1'b0;
    else if (seed_wr && seed_bad)
      comm_err_reg <= 1'b1;
    else if (wr_take && avs_address_in == OFS_STATUS &&
             avs_writedata_in[ST_COMM_BIT])
      comm_err_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // error and refresh counters

  assign err_plus = {1'b0, error_count_value_reg} + 5'h02;

  // saturating at the limit keeps the equality test of the reaction stable
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      error_count_value_reg <= 4'h0;
    else if (state_reg == ST_RESET)
      error_count_value_reg <= 4'h0;
    else if (bad)
    begin
      if (err_plus >= {1'b0, err_lim})
        error_count_value_reg <= err_lim;
      else
        error_count_value_reg <= err_plus[3:0];
    end
    else if (good && refresh_count_value_reg == rfr_lim &&
             error_count_value_reg != 4'h0)
      error_count_value_reg <= error_count_value_reg - 4'h1;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      refresh_count_value_reg <= 3'h0;
    else if (bad || state_reg == ST_RESET)
      refresh_count_value_reg <= 3'h0;
    else if (good && refresh_count_value_reg != rfr_lim)
      refresh_count_value_reg <= refresh_count_value_reg + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // safe state held until errors are paid back in normal running
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      safe_reg <= 1'b0;
    else if (trip_safe || enter_recover || state_reg == ST_RECOVER)
      safe_reg <= 1'b1;
    else if (state_reg == ST_RUN && error_count_value_reg == 4'h0)
      safe_reg <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reset_output_n_out <= 1'b1;
      safe_state_output_n_out <= 1'b1;
    end
    else
    begin
      reset_output_n_out <= (state_reg != ST_RESET);
      safe_state_output_n_out <= !safe_reg;
    end
  end

endmodule

`default_nettype wire

/* design/wd_pkg.sv */
// constants, field layouts and helper functions for the windowed watchdog
package wd_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned RESET_PULSE_MS = 1;
  localparam int unsigned RESET_PULSE_CYCLES = RESET_PULSE_MS * MS_CYCLES;

  // register byte offsets on the avalon slave
  localparam logic [4:0] OFS_WINDOW = 5'h00;
  localparam logic [4:0] OFS_CONFIG = 5'h04;
  localparam logic [4:0] OFS_SEED = 5'h08;
  localparam logic [4:0] OFS_ANSWER = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // window register fields
  localparam int unsigned WIN_PERIOD_LSB = 0;
  localparam int unsigned WIN_DUTY_LSB = 4;
  localparam int unsigned WIN_RECOV_LSB = 8;
  // config register fields
  localparam int unsigned CFG_ERRLIM_LSB = 0;
  localparam int unsigned CFG_RFRLIM_LSB = 2;
  localparam int unsigned CFG_REACT_LSB = 4;
  // status register fields
  localparam int unsigned ST_ERR_LSB = 0;
  localparam int unsigned ST_RFR_LSB = 4;
  localparam int unsigned ST_INIT_BIT = 8;
  localparam int unsigned ST_COMM_BIT = 9;
  localparam int unsigned ST_SAFE_BIT = 10;
  localparam int unsigned ST_DIS_BIT = 11;
  localparam int unsigned ST_RECOV_BIT = 12;
  localparam int unsigned ST_CLOSED_BIT = 13;

  // reset values and special codes
  localparam logic [3:0] PERIOD_RESET = 4'h3;
  localparam logic [2:0] DUTY_RESET = 3'h2;
  localparam logic [3:0] RECOV_RESET = 4'hB;
  localparam logic [1:0] ERRLIM_RESET = 2'h1;
  localparam logic [1:0] RFRLIM_RESET = 2'h0;
  localparam logic [1:0] REACT_RESET = 2'h0;
  localparam logic [15:0] SEED_RESET = 16'h5AB2;
  localparam logic [3:0] CODE_DISABLE = 4'h0;
  localparam logic [15:0] SEED_ZERO = 16'h0000;
  localparam logic [15:0] SEED_ONES = 16'hFFFF;
  localparam logic [1:0] REACT_SAFE = 2'h1;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN = 2'b01,
    ST_RECOVER = 2'b10,
    ST_RESET = 2'b11
  } wd_state_t;

  // window length in ms for a period or recovery code
  function automatic logic [10:0] period_ms(input logic [3:0] code);
    case (code)
      4'h1: period_ms = 11'h001;
      4'h2: period_ms = 11'h002;
      4'h3: period_ms = 11'h003;
      4'h4: period_ms = 11'h004;
      4'h5: period_ms = 11'h006;
      4'h6: period_ms = 11'h008;
      4'h7: period_ms = 11'h00C;
      4'h8: period_ms = 11'h010;
      4'h9: period_ms = 11'h018;
      4'hA: period_ms = 11'h020;
      4'hB: period_ms = 11'h040;
      4'hC: period_ms = 11'h080;
      4'hD: period_ms = 11'h100;
      4'hE: period_ms = 11'h200;
      4'hF: period_ms = 11'h400;
      default: period_ms = 11'h000;
    endcase
  endfunction

  // closed part of the window in sixteenths
  function automatic logic [4:0] closed_16ths(input logic [2:0] code);
    case (code)
      3'h0: closed_16ths = 5'h05;
      3'h1: closed_16ths = 5'h06;
      3'h3: closed_16ths = 5'h0A;
      3'h4: closed_16ths = 5'h0B;
      default: closed_16ths = 5'h08;
    endcase
  endfunction

  function automatic logic [3:0] err_max(input logic [1:0] code);
    case (code)
      2'h0: err_max = 4'h8;
      2'h1: err_max = 4'h6;
      2'h2: err_max = 4'h4;
      default: err_max = 4'h2;
    endcase
  endfunction

  function automatic logic [2:0] rfr_max(input logic [1:0] code);
    case (code)
      2'h0: rfr_max = 3'h6;
      2'h1: rfr_max = 3'h4;
      2'h2: rfr_max = 3'h2;
      default: rfr_max = 3'h1;
    endcase
  endfunction

  // expected challenge answer; the controller must use the same function
  function automatic logic [15:0] challenge_answer(input logic [15:0] q);
    challenge_answer = ~q;
  endfunction

  // next question: fibonacci lfsr, taps 16,14,13,11
  function automatic logic [15:0] lfsr_step(input logic [15:0] q);
    lfsr_step = {q[14:0], q[15] ^ q[13] ^ q[12] ^ q[10]};
  endfunction

endpackage

/* verif/wd_props.sv */
// checker: bus handshake and output timing of the windowed watchdog
`timescale 1ns/1ns
`default_nettype none

module wd_props
  import wd_pkg::*;
#(
  parameter int unsigned RST_CYC = 4
)
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic reset_output_n_out,
  input wire logic safe_state_output_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  ////////////////////////////////////////////////////////////////////////////
  logic req;
  logic rd_done;
  logic mapped;
  logic [31:0] low_cnt;

  // request, completed read and decode of the five mapped offsets
  assign req = avs_read_in | avs_write_in;
  assign rd_done = avs_read_in & ~avs_waitrequest_out;
  assign mapped = avs_address_in inside {OFS_WINDOW, OFS_CONFIG, OFS_SEED,
    OFS_ANSWER, OFS_STATUS};

  // clocks spent low by the reset output; a counter keeps the check cheap
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
      low_cnt <= '0;
    else
      low_cnt <= reset_output_n_out ? '0 : low_cnt + 1;

  ////////////////////////////////////////////////////////////////////////////
  // a read that has just been answered
  sequence s_read_done;
    rd_done;
  endsequence

  first_wait_a: assert property ($rose(req) |-> avs_waitrequest_out)
    else $error("first access cycle not stalled");
  one_wait_a: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("access not answered after one wait");
  idle_wait_a: assert property (!req |-> !avs_waitrequest_out)
    else $error("waitrequest high with no access");
  upper_zero_a: assert property (s_read_done |-> avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  unmapped_zero_a: assert property (s_read_done ##0 !mapped |-> avs_readdata_out == 32'h00000000)
    else $error("unmapped read not zero");
  count_range_a: assert property (s_read_done ##0 avs_address_in == OFS_STATUS
    |-> avs_readdata_out[3:0] <= 4'h8 && avs_readdata_out[6:4] <= 3'h6)
    else $error("counter field beyond its ceiling");
  pulse_len_a: assert property ($rose(reset_output_n_out) |-> low_cnt == RST_CYC)
    else $error("reset pulse length wrong");
  pulse_safe_a: assert property ($fell(reset_output_n_out) |-> ##[0:2] !safe_state_output_n_out)
    else $error("reset pulse without safe state");
  release_high_a: assert property ($rose(nrst_in) |-> reset_output_n_out && safe_state_output_n_out)
    else $error("outputs active after power-on reset");
endmodule

bind windowed_safety_watchdog wd_props #(.RST_CYC(WD_RESET_CYCLES)) i_wd_props (
  .clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .reset_output_n_out(reset_output_n_out),
  .safe_state_output_n_out(safe_state_output_n_out));

`default_nettype wire

/* verif/wd_mcu_model.sv */
// partner model: the controller side of the register bus
`timescale 1ns/1ns
`default_nettype none

module wd_mcu_model
(
  input wire logic clk_in,
  input wire logic [31:0] avs_readdata_in,
  input wire logic avs_waitrequest_in,
  output logic [4:0] avs_address_out,
  output logic avs_read_out,
  output logic avs_write_out,
  output logic [31:0] avs_writedata_out,
  output logic hung_out
);
  // idle bus from time zero
  initial
  begin
    avs_address_out = 5'h00;
    avs_read_out = 1'b0;
    avs_write_out = 1'b0;
    avs_writedata_out = 32'h00000000;
    hung_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer to a question; must match the device's own check
  function automatic logic [15:0] calc(input logic [15:0] qv);
    calc = ~qv;
  endfunction

  // one access, held until waitrequest is sampled low; bounded wait
  task automatic xfer(input logic w, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] qv);
    int n;
    @(posedge clk_in);
    avs_read_out <= ~w;
    avs_write_out <= w;
    avs_address_out <= a;
    avs_writedata_out <= d;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (avs_waitrequest_in !== 1'b0 && n < 50);
    qv = avs_readdata_in;
    if (avs_waitrequest_in !== 1'b0)
      hung_out <= 1'b1;
    avs_read_out <= 1'b0;
    avs_write_out <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* verif/windowed_safety_watchdog_bench.sv */
// self-checking bench for the windowed safety watchdog
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("mismatch at %0t: got %0h want %0h", $time, got, exp); \
    end \
  end

module windowed_safety_watchdog_bench import wd_pkg::*;;
  logic clk_in, nrst_in, fmode, frec, fault, rd_s, wr_s, wt, rst_n, safe_n;
  logic hung;
  logic [4:0] adr;
  logic [31:0] wd, rdat, q;
  logic [15:0] e;
  int error_cnt = 0;
  int compares = 0;

  // 50 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // short ms so windows are 48 clocks; pulse of 4 clocks
  windowed_safety_watchdog #(.WD_MS_CYCLES(16), .WD_RESET_CYCLES(4))
    i_windowed_safety_watchdog (.clk_in(clk_in), .nrst_in(nrst_in),
    .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s),
    .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .fused_mode_select_in(fmode),
    .fused_recovery_enable_in(frec), .mcu_fault_inputs_in(fault),
    .reset_output_n_out(rst_n), .safe_state_output_n_out(safe_n));
  wd_mcu_model i_wd_mcu_model (.clk_in(clk_in), .avs_readdata_in(rdat),
    .avs_waitrequest_in(wt), .avs_address_out(adr), .avs_read_out(rd_s),
    .avs_write_out(wr_s), .avs_writedata_out(wd), .hung_out(hung));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    i_wd_mcu_model.xfer(1'b0, a, 32'h00000000, d);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_wd_mcu_model.xfer(1'b1, a, d, x);
  endtask

  // reset held for three clocks
  task automatic do_reset;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
  endtask

  // bounded wait for the reset output to reach a level
  task automatic wait_rst(input logic lvl);
    int n;
    n = 0;
    while (rst_n !== lvl && n < 60)
    begin
      @(posedge clk_in);
      n++;
    end
    if (rst_n !== lvl)
    begin
      error_cnt++;
      $display("mismatch at %0t: reset output never reached level", $time);
      conclude();
    end
  endtask

  // answer early in the open part, then read the two counters
  task automatic refresh(input logic [15:0] v, input logic [6:0] x);
    repeat (26) @(posedge clk_in);
    wr(OFS_ANSWER, {16'h0000, v});
    rd(OFS_STATUS, q);
    `CHK(q[6:0], x);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    rd(OFS_WINDOW, q);
    `CHK(q, 32'h00000B23);
    rd(OFS_CONFIG, q);
    `CHK(q, 32'h00000001);
    rd(OFS_SEED, q);
    `CHK(q, 32'h00005AB2);
    rd(OFS_STATUS, q);
    `CHK(q, 32'h00000100);
    rd(5'h14, q);
    `CHK(q, 32'h00000000);
    $display("defaults test done");
  endtask

  // simple mode: bad seeds, counters, closed window, reset reaction
  task automatic t_simple;
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_STATUS, 32'h00000200);
      wr(OFS_SEED, i ? 32'h00000000 : 32'h0000FFFF);
      rd(OFS_STATUS, q);
      `CHK(q[9], 1'b1);
      rd(OFS_SEED, q);
      `CHK(q, 32'h00005AB2);
    end
    wr(OFS_CONFIG, 32'h0000002E);
    wr(OFS_SEED, 32'h00001234);
    wr(OFS_ANSWER, 32'h00001234);
    rd(OFS_STATUS, q);
    `CHK(q[8:0], 9'h010);
    refresh(16'h1235, 7'h02);
    refresh(16'h1234, 7'h12);
    refresh(16'h1234, 7'h11);
    // duty 0 written now must not shorten the closed part of this window
    wr(OFS_WINDOW, 32'h00000B03);
    repeat (12) @(posedge clk_in);
    wr(OFS_ANSWER, 32'h00001234);
    rd(OFS_STATUS, q);
    `CHK(q[6:0], 7'h03);
    repeat (12) @(posedge clk_in);
    wr(OFS_ANSWER, 32'h00001234);
    rd(OFS_STATUS, q);
    `CHK(q[6:0], 7'h13);
    repeat (26) @(posedge clk_in);
    wr(OFS_ANSWER, 32'h00000000);
    wait_rst(1'b0);
    repeat (2) @(posedge clk_in);
    `CHK(safe_n, 1'b0);
    wait_rst(1'b1);
    rd(OFS_STATUS, q);
    `CHK(q[8:0], 9'h100);
    $display("simple test done");
  endtask

  // challenge mode with fault recovery
  task automatic t_challenge;
    wr(OFS_SEED, 32'h00000000);
    rd(OFS_STATUS, q);
    `CHK(q[9], 1'b1);
    rd(OFS_SEED, q);
    `CHK(q, 32'h00005AB2);
    wr(OFS_WINDOW, 32'h00000123);
    rd(OFS_ANSWER, q);
    `CHK(q[15:0], 16'h5AB2);
    wr(OFS_ANSWER, {16'h0000, i_wd_mcu_model.calc(q[15:0])});
    e = {q[14:0], q[15] ^ q[13] ^ q[12] ^ q[10]};
    rd(OFS_ANSWER, q);
    `CHK(q[15:0], e);
    repeat (26) @(posedge clk_in);
    wr(OFS_ANSWER, {16'h0000, e});
    rd(OFS_ANSWER, q);
    `CHK(q[15:0], e);
    fault <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK(safe_n, 1'b0);
    rd(OFS_STATUS, q);
    `CHK(q[12], 1'b1);
    fault <= 1'b0;
    wr(OFS_ANSWER, {16'h0000, i_wd_mcu_model.calc(e)});
    rd(OFS_STATUS, q);
    `CHK(q[12], 1'b0);
    fault <= 1'b1;
    wait_rst(1'b0);
    fault <= 1'b0;
    wait_rst(1'b1);
    rd(OFS_STATUS, q);
    `CHK(q[8], 1'b1);
    // period code 0 from init: once closed, no timeouts and answers ignored
    wr(OFS_WINDOW, 32'h00000120);
    rd(OFS_ANSWER, q);
    wr(OFS_ANSWER, {16'h0000, i_wd_mcu_model.calc(q[15:0])});
    wr(OFS_ANSWER, 32'h00000000);
    repeat (60) @(posedge clk_in);
    rd(OFS_STATUS, q);
    `CHK(q[11:0], 12'hA10);
    $display("challenge test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // a stuck bus ends the run
  always @(posedge hung)
  begin
    error_cnt++;
    $display("mismatch at %0t: bus access never answered", $time);
    conclude();
  end

  initial
  begin
    nrst_in = 1'b0;
    fmode = 1'b0;
    frec = 1'b0;
    fault = 1'b0;
    do_reset();
    t_defaults();
    t_simple();
    @(posedge clk_in);
    fmode <= 1'b1;
    frec <= 1'b1;
    do_reset();
    t_challenge();
    conclude();
  end
endmodule

`default_nettype wire
